// ===== bench/icst_spindle_model.sv
// Spindle model answering the spin-up request of the block
`timescale 1ns/10ps
module icst_spindle_model #(
  parameter int SPIN_CYC = 5
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic spin_on_q,
  output logic spin_at_speed
);
  int cnt;
  // Speed comes some cycles after switch-on; it is lost at once when off
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n || !spin_on_q)
    begin
      cnt <= 0;
      spin_at_speed <= 1'b0;
    end
    else if (cnt < SPIN_CYC)
      cnt <= cnt + 1;
    else
      spin_at_speed <= 1'b1;
  end
endmodule

// ===== bench/idle_command_standby_timer_bench.sv
// Self-checking bench for the idle command and standby timer
`timescale 1ns/10ps
module idle_command_standby_timer_bench;
  localparam int TICK = 2;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_count = 8'h00;
  logic host_access = 1'b0;
  logic spin_at_speed, done_q, spin_on_q, standby_q, timer_on_q;
  icst_pkg::icst_resp_t resp_q;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 96254;
  int k;
  logic [7:0] v;
  // Clock of 8 ns period
  always #4 clock = ~clock;
  icst_idle_timer #(.TICK_CYC(TICK)) dut_u (.clock(clock), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_count(cmd_count),
    .host_access(host_access), .spin_at_speed(spin_at_speed), .resp_q(resp_q),
    .done_q(done_q), .spin_on_q(spin_on_q), .standby_q(standby_q), .timer_on_q(timer_on_q));
  icst_spindle_model #(.SPIN_CYC(5)) spin_u (.clock(clock), .arst_n(arst_n),
    .spin_on_q(spin_on_q), .spin_at_speed(spin_at_speed));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Interval in cycles; only short codes are run, the longest ones would overrun the watchdog
  function automatic int span(input logic [7:0] c);
    return (c > 8'd240) ? (c - 240) * 1800 * TICK : c * 5 * TICK;
  endfunction
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Strobe one command, then count cycles until completion
  // k ends as the number of edges between the taking edge and the done pulse
  task automatic issue(input logic [7:0] code, input logic [7:0] cnt);
    @(posedge clock);
    cmd_code <= code;
    cmd_count <= cnt;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    k = 0;
    #1;
    while (k < 100 && done_q !== 1'b1)
    begin
      @(posedge clock) #1;
      k++;
    end
  endtask
  // Tolerance of a few cycles covers where the count starts
  task automatic expire(input int want);
    int n;
    for (n = 0; n < want + 8 && standby_q !== 1'b1; n++)
      @(posedge clock) #1;
    chk(16'(n >= want - 3 && n <= want + 4), 16'h0001);
    chk({15'h0, spin_on_q}, 16'h0000);
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk(resp_q, 16'h0000);
    chk({12'h0, done_q, spin_on_q, standby_q, timer_on_q}, 16'h0002);
    for (int i = 0; i < 2; i++)
    begin
      v = 8'(1 + {$random(seed)} % 3);
      issue(i ? 8'h97 : 8'he3, v);
      chk(resp_q, 16'h5000);
      chk({13'h0, spin_on_q, standby_q, timer_on_q}, 16'h0005);
      expire(span(v) - k);
    end
    $display("Test idle and expiry done");
    issue(8'he3, 8'd3);
    repeat (8) @(posedge clock);
    issue(8'h97, 8'h00);
    chk(16'(k), 16'h0001);
    chk({13'h0, spin_on_q, standby_q, timer_on_q}, 16'h0004);
    repeat (40) @(posedge clock) #1;
    chk({15'h0, standby_q}, 16'h0000);
    $display("Test spinning and disabled timer done");
    issue(8'he3, 8'd2);
    issue(8'he1, 8'h00);
    issue(8'h95, 8'h00);
    chk({15'h0, timer_on_q}, 16'h0001);
    expire(span(8'd2) - k);
    issue(8'he3, 8'd3);
    repeat (span(8'd3) / 2) @(posedge clock);
    host_access <= 1'b1;
    @(posedge clock);
    host_access <= 1'b0;
    expire(span(8'd3));
    $display("Test immediate and access done");
    repeat (4)
    begin
      v = 8'($random(seed));
      if (v == 8'he3 || v == 8'h97 || v == 8'he1 || v == 8'h95)
        v = 8'h00;
      issue(v, v);
      chk(resp_q, 16'h4104);
    end
    $display("Test refused codes done");
    give_verdict();
  end
  // Watchdog against a hang
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule

// ===== rtl/icst_idle_timer.sv
// Idle command interpreter with automatic standby countdown
`timescale 1ns/10ps
`include "icst_map.svh"

// Functional notes
// R1: Opcodes E3h and 97h both mean the Idle request, handled identically.
// R2: Idle request enters Idle at once, loads timer from parameter, counts down.
// R3: Entering Idle spins spindle up unless it is already rotating.
// R4: In Idle the spindle keeps turning and commands get no added latency.
// R5: Parameter zero stops the timer; non-zero enables automatic power-down.
// R6: Values scale by 5 seconds, upper range (value-240) times 30 minutes.
// R7: Fixed intervals 21 min, 8 h, 21 min 10 s, 21 min 15 s.
// R8: Timer expiry without host access drops the device into Standby.
// R9: Each host access before expiry reloads the full interval.
// R10: Idle Immediate enters Idle and keeps the interval and enable unchanged.
// R11: 1-240 five-second steps, 241-251 half hours, 252-255 fixed codes.
// R12: Completion clears busy and sets ready; failure sets error with abort only.
module icst_idle_timer #(
  parameter int unsigned TICK_CYC = `ICST_TICK_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_count,
  input wire logic host_access,
  input wire logic spin_at_speed,
  output icst_pkg::icst_resp_t resp_q,
  output logic done_q,
  output logic spin_on_q,
  output logic standby_q,
  output logic timer_on_q
);

  // ---------------------------------------------------------------
  // Decode and interval lookup
  // ---------------------------------------------------------------
  logic is_idle;
  logic is_now;
  logic [14:0] secs;
  icst_pkg::icst_mode_t mode_q;
  logic [14:0] load_q;
  logic [14:0] left_q;
  logic [31:0] tick_q;
  logic pend_q;
  logic fail_q;

  assign is_idle = cmd_valid && (cmd_code == `ICST_OP_IDLE || cmd_code == `ICST_OP_IDLE_ALT);
  assign is_now = cmd_valid && (cmd_code == `ICST_OP_IDLE_NOW ||
                                cmd_code == `ICST_OP_IDLE_NOW_ALT);

  // Interval in seconds; the widest case, 8 hours, fits in 15 bits
  always_comb
  begin
    if (cmd_count <= `ICST_SPLIT)
      secs = 15'(cmd_count * `ICST_STEP_S); // see R6 see R11
    else if (cmd_count <= `ICST_FORMULA_TOP)
      secs = 15'((cmd_count - `ICST_SPLIT) * `ICST_HALF_HOUR_S); // see R6 see R11
    else
    begin
      case (cmd_count[1:0]) // see R7 see R11
        2'h0: secs = 15'(`ICST_FIX0_S);
        2'h1: secs = 15'(`ICST_FIX1_S);
        2'h2: secs = 15'(`ICST_FIX2_S);
        default: secs = 15'(`ICST_FIX3_S);
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power mode and spindle
  // ---------------------------------------------------------------
  // Spin-up is skipped when the spindle already reports speed
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= icst_pkg::ICST_STANDBY;
      spin_on_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else if (is_idle || is_now)
    begin
      mode_q <= spin_at_speed ? icst_pkg::ICST_IDLE : icst_pkg::ICST_SPIN; // see R2 see R3 see R10
      spin_on_q <= 1'b1; // see R3 see R4
      standby_q <= 1'b0;
    end
    else if (timer_on_q && left_q == 15'h0 && tick_q == 32'h0 && mode_q == icst_pkg::ICST_IDLE
             && !host_access)
    begin
      mode_q <= icst_pkg::ICST_STANDBY; // see R8
      spin_on_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else if (mode_q == icst_pkg::ICST_SPIN && spin_at_speed)
      mode_q <= icst_pkg::ICST_IDLE;
  end

  // ---------------------------------------------------------------
  // Standby countdown
  // ---------------------------------------------------------------
  // A seconds counter driven by a one-second prescaler keeps the wide count cheap
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_on_q <= 1'b0;
      load_q <= 15'h0;
      left_q <= 15'h0;
      tick_q <= 32'h0;
    end
    else if (is_idle)
    begin
      timer_on_q <= cmd_count != 8'h0; // see R5
      load_q <= secs;
      left_q <= secs; // see R2
      tick_q <= TICK_CYC - 1;
    end
    else if (host_access || is_now)
    begin
      left_q <= load_q; // see R9
      tick_q <= TICK_CYC - 1;
    end
    else if (timer_on_q && mode_q != icst_pkg::ICST_STANDBY)
    begin
      if (tick_q != 32'h0)
        tick_q <= tick_q - 32'h1;
      else if (left_q != 15'h0)
      begin
        left_q <= left_q - 15'h1;
        tick_q <= TICK_CYC - 1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Completion status
  // ---------------------------------------------------------------
  // Idle answers at once; completion waits for speed only on the spin-up path
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q <= 1'b0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
      resp_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (cmd_valid && !is_idle && !is_now)
      begin
        resp_q <= '0;
        resp_q.status[`ICST_ST_RDY] <= 1'b1;
        resp_q.status[`ICST_ST_ERR] <= 1'b1; // see R12
        resp_q.error[`ICST_ER_ABT] <= 1'b1;
        done_q <= 1'b1;
      end
      else if (is_idle || is_now)
      begin
        pend_q <= 1'b1;
        fail_q <= 1'b0;
        resp_q <= '0;
        resp_q.status[`ICST_ST_BSY] <= 1'b1;
      end
      else if (pend_q && mode_q == icst_pkg::ICST_IDLE)
      begin
        pend_q <= 1'b0;
        resp_q <= '0;
        resp_q.status[`ICST_ST_RDY] <= 1'b1; // see R12
        resp_q.status[`ICST_ST_DSC] <= 1'b1;
        resp_q.status[`ICST_ST_ERR] <= fail_q;
        done_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_both_codes: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle |=> !standby_q && spin_on_q) else $error("idle code not taken"); // see R1
  a_timer_zero: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && cmd_count == 8'h0 |=> !timer_on_q) else $error("zero kept timer"); // see R5
  a_load_secs: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && cmd_count == 8'd241 |=> left_q == 15'd1800) else $error("bad load"); // see R6
  a_fixed_code: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && cmd_count == 8'hfd |=> load_q == 15'd28800) else $error("bad fixed"); // see R7
  a_reload_access: assert property (@(posedge clock) disable iff (!arst_n)
    host_access && !is_idle |=> left_q == $past(load_q)) else $error("no reload"); // see R9
  a_keep_interval: assert property (@(posedge clock) disable iff (!arst_n)
    is_now && !is_idle |=> $stable(load_q) && $stable(timer_on_q))
    else $error("immediate changed interval"); // see R10
  a_spin_idle: assert property (@(posedge clock) disable iff (!arst_n)
    mode_q == icst_pkg::ICST_IDLE |-> spin_on_q) else $error("idle without spin"); // see R4
  a_abort_flags: assert property (@(posedge clock) disable iff (!arst_n)
    cmd_valid && !is_idle && !is_now |=> resp_q.error == 8'h04 && done_q)
    else $error("abort response wrong"); // see R12
  a_expire_sby: assert property (@(posedge clock) disable iff (!arst_n)
    timer_on_q && left_q == 15'h0 && tick_q == 32'h0 && mode_q == icst_pkg::ICST_IDLE &&
    !host_access && !cmd_valid |=> standby_q) else $error("no standby"); // see R8
  a_fast_done: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && spin_at_speed ##1 !cmd_valid |=> done_q) else $error("slow idle"); // see R2

  // A spindle already at speed must go straight to Idle, no spin-up state
  a_spin_skip: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && spin_at_speed |=> mode_q == icst_pkg::ICST_IDLE)
    else $error("spin-up not skipped"); // see R3

  // Busy must show while an Idle request is in flight
  a_busy_shown: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle |=> resp_q.status[`ICST_ST_BSY]) else $error("busy not shown"); // see R12

  // Two units of five seconds give ten seconds
  a_timer_load: assert property (@(posedge clock) disable iff (!arst_n)
    is_idle && cmd_count == 8'd2 |=> left_q == 15'd10) else $error("bad short load"); // see R2

  // Each elapsed second takes exactly one off the remaining count
  a_count_down: assert property (@(posedge clock) disable iff (!arst_n)
    timer_on_q && mode_q == icst_pkg::ICST_IDLE && tick_q == 32'h0 && left_q != 15'h0 &&
    !host_access && !cmd_valid |=> left_q == $past(left_q) - 15'h1)
    else $error("count step wrong"); // see R2

  // Nothing but a host access or a command may move the frozen count
  a_freeze_sby: assert property (@(posedge clock) disable iff (!arst_n)
    mode_q == icst_pkg::ICST_STANDBY && !host_access && !cmd_valid |=> $stable(left_q))
    else $error("count moved in standby"); // see R8

endmodule

// ===== rtl/icst_map.svh
// Constants for the idle command and standby timer block
`ifndef ICST_MAP_SVH
`define ICST_MAP_SVH
`define ICST_OP_IDLE 8'he3
`define ICST_OP_IDLE_ALT 8'h97
`define ICST_OP_IDLE_NOW 8'he1
`define ICST_OP_IDLE_NOW_ALT 8'h95
`define ICST_CLK_MHZ 125
`define ICST_TICK_MS 1000
`define ICST_TICK_CYC (`ICST_TICK_MS * 1000 * `ICST_CLK_MHZ)
`define ICST_STEP_S 5
`define ICST_HALF_HOUR_S 1800
`define ICST_SPLIT 8'd240
`define ICST_FORMULA_TOP 8'd251
`define ICST_FIX0_S 1260
`define ICST_FIX1_S 28800
`define ICST_FIX2_S 1270
`define ICST_FIX3_S 1275
`define ICST_ST_BSY 7
`define ICST_ST_RDY 6
`define ICST_ST_DSC 4
`define ICST_ST_ERR 0
`define ICST_ER_ABT 2
`endif

// ===== rtl/icst_pkg.sv
// Types for the idle command and standby timer block
package icst_pkg;
  typedef enum {ICST_IDLE, ICST_SPIN, ICST_STANDBY} icst_mode_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
  } icst_resp_t;
endpackage
